// ===== core/sif_top.sv
/*
 * Input failover, output switch, power-up straps and indicator logic.
 * Assumes receivers give signal-present and lock levels asynchronously;
 * they are synchronised here. Registers on a plain strobe port.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R01) Manual or automatic priority input choice
// (R02) Three levels: main, backup 1, backup 2
// (R03) Lost source cascades to next level
// (R04) Unused backup 2 stops failover at backup 1
// (R05) Switch rule: loss of lock or signal
// (R06) Configurable hold and lock times
// (R07) Non-latched only allowed under loss of signal
// (R08) Two-by-two crosspoint, true and inverted outputs
// (R09) Switch off through, on processed
// (R10) Override strap sampled at power-up only
// (R11) Factory default strap restores defaults
// (R12) Card status orange, green or red
// (R13) Video LED red, orange, green
// (R14) Sync LED red, orange, green
// (R15) Audio LED by embedded group count
// (R16) Locate blinks all LEDs together
// (R17) Running light after download, then reboot
// (R18) Alarm output follows card status, open alarm
// (R19) Four active-low GPIs, reserved, unused
// (R20) Loss freezes for hold, then generator
// (R21) Live again after lock time locked
// (R22) Latched stays on backup until re-applied
module sif_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        elec_sig_i,
	input  wire logic        elec_lock_i,
	input  wire logic        opt_sig_i,
	input  wire logic        opt_lock_i,
	input  wire logic        sync_sig_i,
	input  wire logic        sync_lock_i,
	input  wire logic [2:0]  audio_groups_i,
	input  wire logic        fuse_trip_i,
	input  wire logic        prog_fail_i,
	input  wire logic        remote_override_switch_i,
	input  wire logic        factory_default_switch_i,
	input  wire logic        input_medium_select_i,
	input  wire logic        out1_processed_select_i,
	input  wire logic        out2_processed_select_i,
	input  wire logic [3:0]  gpi_n_i,
	output logic      [1:0]  src_sel_o,
	output logic             freeze_o,
	output logic             gen_sel_o,
	output logic      [1:0]  prio_level_o,
	output logic             out1_processed_o,
	output logic             out2_processed_o,
	output logic      [1:0]  led_card_o,
	output logic      [1:0]  led_video_o,
	output logic      [1:0]  led_sync_o,
	output logic      [1:0]  led_audio_o,
	output logic             alarm_oe_o,
	output logic             reboot_o
);
	// Two-stage synchronisers for all pin inputs
	localparam int NS = 13;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;
	logic [NS-1:0] pins;
	assign pins = {elec_sig_i, elec_lock_i, opt_sig_i, opt_lock_i, sync_sig_i, sync_lock_i,
		fuse_trip_i, prog_fail_i, remote_override_switch_i, factory_default_switch_i,
		input_medium_select_i, out1_processed_select_i, out2_processed_select_i};
	always_ff @(posedge clk_i) begin
		s1_r <= pins;
		s2_r <= s1_r;
	end
	logic [2:0] aud_s1_r;
	logic [2:0] aud_s2_r;
	logic [3:0] gpi_s1_r;
	logic [3:0] gpi_s2_r;
	always_ff @(posedge clk_i) begin
		aud_s1_r <= audio_groups_i;
		aud_s2_r <= aud_s1_r;
		gpi_s1_r <= gpi_n_i;
		gpi_s2_r <= gpi_s1_r;
	end
	// GPIs are active low but reserved; sampled and only reported in the status word
	wire [3:0] gpi_act = ~gpi_s2_r; // R19
	wire e_sig  = s2_r[12];
	wire e_lock = s2_r[11];
	wire o_sig  = s2_r[10];
	wire o_lock = s2_r[9];
	wire y_sig  = s2_r[8];
	wire y_lock = s2_r[7];
	wire fuse   = s2_r[6];
	wire pfail  = s2_r[5];
	wire ovr_s  = s2_r[4];
	wire fdef_s = s2_r[3];
	wire med_s  = s2_r[2];
	wire o1_s   = s2_r[1];
	wire o2_s   = s2_r[0];

	// Straps caught once, on the third clock edge after reset release
	logic       boot_r;
	logic [1:0] bcnt_r;
	logic       ovr_r;
	logic       fdef_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bcnt_r <= 2'h0;
			boot_r <= 1'b1;
			ovr_r  <= 1'b0;
			fdef_r <= 1'b0;
		end else if (boot_r) begin
			bcnt_r <= bcnt_r + 2'h1;
			if (bcnt_r == 2'h2) begin
				boot_r <= 1'b0;
				ovr_r  <= ovr_s; // R10
				fdef_r <= fdef_s; // R11
			end
		end
	end
	wire strap_go = boot_r && (bcnt_r == 2'h2);

	// Register file
	logic [7:0]  ctrl_r;
	logic [6:0]  prio_r;
	logic [15:0] hold_r;
	logic [15:0] lock_r;
	logic [15:0] rdata_r;
	wire wr_ctrl = wr_i && (addr_i == sif_pkg::A_CTRL);
	wire wr_prio = wr_i && (addr_i == sif_pkg::A_PRIO);
	wire wr_cmd  = wr_i && (addr_i == sif_pkg::A_CMD);
	wire apply   = (wr_cmd && wdata_i[sif_pkg::K_APPLY]) || wr_ctrl || wr_prio;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= sif_pkg::CTRL_RST;
			prio_r <= {1'b0, sif_pkg::PRIO_RST};
			hold_r <= sif_pkg::HOLD_RST;
			lock_r <= sif_pkg::LOCK_RST;
		end else if (strap_go && fdef_s) begin
			// Factory defaults win over stored setup
			ctrl_r <= sif_pkg::CTRL_RST; // R11
			prio_r <= {1'b0, sif_pkg::PRIO_RST};
			hold_r <= sif_pkg::HOLD_RST;
			lock_r <= sif_pkg::LOCK_RST;
		end else begin
			if (wr_ctrl)
				ctrl_r <= wdata_i[7:0];
			if (wr_prio)
				prio_r <= wdata_i[6:0];
			if (wr_i && addr_i == sif_pkg::A_HOLD)
				hold_r <= wdata_i; // R06
			if (wr_i && addr_i == sif_pkg::A_LOCK)
				lock_r <= wdata_i; // R06
		end
	end

	// Effective configuration: override strap picks local switches
	wire       auto_m = ovr_r ? 1'b0 : ctrl_r[sif_pkg::C_AUTO]; // R01 R10
	wire       rule_los = ctrl_r[sif_pkg::C_RULE]; // R05
	wire       nonlatch = rule_los && ctrl_r[sif_pkg::C_NLAT]; // R07
	wire [1:0] man_src = ovr_r ? {1'b0, med_s} : ctrl_r[sif_pkg::C_MAN_L +: 2];
	wire       p1 = ovr_r ? o1_s : ctrl_r[sif_pkg::C_OUT1];
	wire       p2 = ovr_r ? o2_s : ctrl_r[sif_pkg::C_OUT2];
	// Extra priority bit marks backup 2 unused; all four codes stay sources
	wire [1:0] lvl_src [3];
	assign lvl_src[0] = prio_r[1:0]; // R02
	assign lvl_src[1] = prio_r[3:2];
	assign lvl_src[2] = prio_r[5:4];
	wire b2_unused = prio_r[sif_pkg::P_B2OFF]; // R04

	// Source health per rule
	function automatic logic src_ok(input logic [1:0] s, input logic los);
		case (s)
			sif_pkg::SRC_ELEC: src_ok = los ? e_sig : e_lock;
			sif_pkg::SRC_OPT:  src_ok = los ? o_sig : o_lock;
			default:           src_ok = 1'b1;
		endcase
	endfunction

	// Priority level tracking
	logic [1:0] lvl_r;
	logic [1:0] lvl_nxt;
	logic [1:0] last_lvl;
	assign last_lvl = b2_unused ? 2'd1 : 2'd2; // R04
	always_comb begin
		lvl_nxt = lvl_r;
		if (apply || !auto_m)
			lvl_nxt = 2'd0; // R22
		else if (!src_ok(lvl_src[lvl_r], rule_los) && lvl_r < last_lvl)
			lvl_nxt = lvl_r + 2'd1; // R03
		else if (nonlatch && lvl_r != 2'd0 && src_ok(lvl_src[0], 1'b1))
			lvl_nxt = 2'd0;
		else if (nonlatch && lvl_r == 2'd2 && src_ok(lvl_src[1], 1'b1))
			lvl_nxt = 2'd1;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			lvl_r <= 2'd0;
		else
			lvl_r <= lvl_nxt;
	end
	wire [1:0] cur_src = auto_m ? lvl_src[lvl_r] : man_src;
	wire       cur_lock = (cur_src == sif_pkg::SRC_ELEC) ? e_lock :
		(cur_src == sif_pkg::SRC_OPT) ? o_lock : 1'b1;
	wire       cur_sig = (cur_src == sif_pkg::SRC_ELEC) ? e_sig :
		(cur_src == sif_pkg::SRC_OPT) ? o_sig : 1'b1;

	// Freeze, generator and relock sequencing, in ms ticks
	logic [14:0] msdiv_r;
	wire         ms_tick = (msdiv_r == 15'(sif_pkg::MS_CYC - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i || ms_tick)
			msdiv_r <= 15'h0000;
		else
			msdiv_r <= msdiv_r + 15'h0001;
	end
	sif_pkg::sif_vst_t vst_r;
	logic [15:0] tcnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vst_r  <= sif_pkg::ST_LIVE;
			tcnt_r <= 16'h0000;
		end else begin
			case (vst_r)
				sif_pkg::ST_LIVE: begin
					tcnt_r <= 16'h0000;
					if (!cur_sig)
						vst_r <= sif_pkg::ST_FREEZE; // R20
				end
				sif_pkg::ST_FREEZE: begin
					if (cur_lock) begin
						vst_r <= sif_pkg::ST_RELOCK;
						tcnt_r <= 16'h0000;
					end else if (tcnt_r >= hold_r)
						vst_r <= sif_pkg::ST_GEN; // R20
					else if (ms_tick)
						tcnt_r <= tcnt_r + 16'h0001;
				end
				sif_pkg::ST_GEN: begin
					tcnt_r <= 16'h0000;
					if (cur_lock)
						vst_r <= sif_pkg::ST_RELOCK;
				end
				sif_pkg::ST_RELOCK: begin
					if (!cur_lock) begin
						vst_r <= sif_pkg::ST_GEN;
						tcnt_r <= 16'h0000;
					end else if (tcnt_r >= lock_r)
						vst_r <= sif_pkg::ST_LIVE; // R21
					else if (ms_tick)
						tcnt_r <= tcnt_r + 16'h0001;
				end
				default: vst_r <= sif_pkg::ST_LIVE;
			endcase
		end
	end

	// Locate blink and firmware running light
	logic [22:0] bl_cnt_r;
	logic        bl_ph_r;
	logic [3:0]  bl_left_r;
	logic        inst_r;
	logic [1:0]  run_pos_r;
	wire bl_wrap = (bl_cnt_r == 23'(sif_pkg::BLINK_CYC - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bl_cnt_r  <= 23'h000000;
			bl_ph_r   <= 1'b0;
			bl_left_r <= 4'h0;
			inst_r    <= 1'b0;
			run_pos_r <= 2'h0;
			reboot_o  <= 1'b0;
		end else begin
			bl_cnt_r <= bl_wrap ? 23'h000000 : bl_cnt_r + 23'h000001;
			if (wr_cmd && wdata_i[sif_pkg::K_LOCATE]) begin
				bl_left_r <= 4'ha; // R16
				bl_ph_r   <= 1'b1;
			end else if (bl_wrap && bl_left_r != 4'h0) begin
				bl_left_r <= bl_left_r - 4'h1;
				bl_ph_r   <= ~bl_ph_r;
			end
			if (wr_cmd && wdata_i[sif_pkg::K_FWDONE])
				inst_r <= 1'b1; // R17
			if (inst_r && bl_wrap)
				run_pos_r <= run_pos_r + 2'h1;
			reboot_o <= inst_r && wr_cmd && wdata_i[sif_pkg::K_INSTOK]; // R17
		end
	end

	// Indicator decode
	wire [1:0] card_st = (fuse || pfail) ? sif_pkg::LED_RED :
		((fdef_r && ovr_r) || boot_r || inst_r) ? sif_pkg::LED_ORG :
		sif_pkg::LED_GRN; // R12
	wire [1:0] vid_st = !cur_sig ? sif_pkg::LED_RED :
		!cur_lock ? sif_pkg::LED_ORG : sif_pkg::LED_GRN; // R13
	wire [1:0] syn_st = !y_sig ? sif_pkg::LED_RED :
		!y_lock ? sif_pkg::LED_ORG : sif_pkg::LED_GRN; // R14
	wire [1:0] aud_st = (aud_s2_r == 3'h0) ? sif_pkg::LED_RED :
		(aud_s2_r >= 3'h4) ? sif_pkg::LED_GRN : sif_pkg::LED_ORG; // R15
	wire locating = (bl_left_r != 4'h0);
	function automatic logic [1:0] led_sel(input logic [1:0] n, input logic [1:0] idx);
		if (inst_r)
			led_sel = (run_pos_r == idx) ? sif_pkg::LED_GRN : sif_pkg::LED_OFF;
		else if (locating)
			led_sel = bl_ph_r ? sif_pkg::LED_GRN : sif_pkg::LED_OFF; // R16
		else
			led_sel = n;
	endfunction

	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_sel_o        <= sif_pkg::SRC_ELEC;
			freeze_o         <= 1'b0;
			gen_sel_o        <= 1'b0;
			prio_level_o     <= 2'd0;
			out1_processed_o <= 1'b0;
			out2_processed_o <= 1'b0;
			led_card_o       <= sif_pkg::LED_ORG;
			led_video_o      <= sif_pkg::LED_OFF;
			led_sync_o       <= sif_pkg::LED_OFF;
			led_audio_o      <= sif_pkg::LED_OFF;
			alarm_oe_o       <= 1'b0;
		end else begin
			src_sel_o        <= cur_src; // R01
			freeze_o         <= (vst_r == sif_pkg::ST_FREEZE); // R20
			gen_sel_o        <= (vst_r == sif_pkg::ST_GEN) || (vst_r == sif_pkg::ST_RELOCK) ||
				(cur_src == sif_pkg::SRC_GEN);
			prio_level_o     <= lvl_r;
			out1_processed_o <= p1; // R08 R09
			out2_processed_o <= p2; // R08 R09
			led_card_o       <= led_sel(card_st, 2'd0);
			led_video_o      <= led_sel(vid_st, 2'd1);
			led_sync_o       <= led_sel(syn_st, 2'd2);
			led_audio_o      <= led_sel(aud_st, 2'd3);
			alarm_oe_o       <= (card_st == sif_pkg::LED_GRN); // R18
		end
	end

	// Read mux, data valid the cycle after the strobe
	wire [15:0] stat = {gpi_act, 2'b00, ovr_r, fdef_r, vst_r, lvl_r, cur_src, cur_lock, cur_sig};
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdata_r <= 16'h0000;
		else if (rd_i) begin
			case (addr_i)
				sif_pkg::A_CTRL: rdata_r <= {8'h00, ctrl_r};
				sif_pkg::A_PRIO: rdata_r <= {9'h000, prio_r};
				sif_pkg::A_HOLD: rdata_r <= hold_r;
				sif_pkg::A_LOCK: rdata_r <= lock_r;
				sif_pkg::A_STAT: rdata_r <= stat;
				default:         rdata_r <= 16'h0000;
			endcase
		end else
			rdata_r <= 16'h0000;
	end
	assign rdata_o = rdata_r;

	// Checks on level stepping, video sequencing and indicators
	a_nonlatch_los: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		auto_m && !rule_los && !apply |=> lvl_r >= $past(lvl_r))
		else $error("level rose back under loss of lock");
	a_cascade_step: assert property (@(posedge clk_i) disable iff (rst_i) // R03
		lvl_r != $past(lvl_r) |-> lvl_r == 2'd0 || lvl_r == $past(lvl_r) + 2'd1 ||
		$past(nonlatch)) else $error("bad level step");
	a_level_bound: assert property (@(posedge clk_i) disable iff (rst_i) // R04
		lvl_r <= last_lvl) else $error("level past last");
	a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R22
		!nonlatch && !apply && auto_m && lvl_r == 2'd1 |=> lvl_r != 2'd0)
		else $error("latched returned");
	a_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		vst_r == sif_pkg::ST_LIVE && !cur_sig |=> vst_r == sif_pkg::ST_FREEZE)
		else $error("no freeze");
	a_relock_time: assert property (@(posedge clk_i) disable iff (rst_i) // R21
		$past(vst_r) == sif_pkg::ST_RELOCK && vst_r == sif_pkg::ST_LIVE |->
		$past(tcnt_r) >= $past(lock_r)) else $error("early live");
	a_alarm_card: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		fuse || pfail || boot_r || inst_r |=> !alarm_oe_o) else $error("alarm not open");
	a_video_led: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		!inst_r && !locating && !cur_sig |=> led_video_o == sif_pkg::LED_RED)
		else $error("video led");
	a_blink_unison: assert property (@(posedge clk_i) disable iff (rst_i) // R16
		$past(locating) && !$past(inst_r) |-> led_card_o == led_audio_o)
		else $error("blink apart");
	c_failover: cover property (@(posedge clk_i) disable iff (rst_i) lvl_r == 2'd2);
	c_gen: cover property (@(posedge clk_i) disable iff (rst_i) vst_r == sif_pkg::ST_GEN);
	c_locate: cover property (@(posedge clk_i) disable iff (rst_i) locating);
	c_reboot: cover property (@(posedge clk_i) disable iff (rst_i) reboot_o);
endmodule : sif_top
`default_nettype wire

// ===== core/sif_pkg.sv
/*
 * Constants and types for the SDI input failover and status block.
 * Assumes a single 25 MHz clock and a synchronous active-high reset.
 */
`default_nettype none
package sif_pkg;
	localparam int unsigned CLK_HZ       = 25000000;
	localparam int unsigned BLINK_MS     = 250;
	localparam int unsigned BLINK_CYC    = (CLK_HZ / 1000) * BLINK_MS;
	localparam int unsigned RUN_MS       = 100;
	localparam int unsigned RUN_CYC      = (CLK_HZ / 1000) * RUN_MS;
	localparam int unsigned HOLD_MS_DEF  = 500;
	localparam int unsigned LOCK_MS_DEF  = 1000;
	localparam int unsigned MS_CYC       = CLK_HZ / 1000;
	// Register offsets, byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_PRIO  = 8'h04;
	localparam logic [7:0] A_HOLD  = 8'h08;
	localparam logic [7:0] A_LOCK  = 8'h0c;
	localparam logic [7:0] A_CMD   = 8'h10;
	localparam logic [7:0] A_STAT  = 8'h14;
	// Control fields
	localparam int unsigned C_AUTO  = 0;
	localparam int unsigned C_RULE  = 1;
	localparam int unsigned C_NLAT  = 2;
	localparam int unsigned C_MED   = 3;
	localparam int unsigned C_MAN_L = 4;
	localparam int unsigned C_OUT1  = 6;
	localparam int unsigned C_OUT2  = 7;
	localparam logic [7:0]  CTRL_RST = 8'h01;
	localparam logic [5:0]  PRIO_RST = 6'h31;
	// Priority word bit that takes backup 2 out of the cascade
	localparam int unsigned P_B2OFF  = 6;
	localparam logic [15:0] HOLD_RST = 16'h01f4;
	localparam logic [15:0] LOCK_RST = 16'h03e8;
	// Command bits
	localparam int unsigned K_APPLY  = 0;
	localparam int unsigned K_LOCATE = 1;
	localparam int unsigned K_FWDONE = 2;
	localparam int unsigned K_INSTOK = 3;
	typedef enum logic [1:0] {
		SRC_ELEC = 2'b00,
		SRC_OPT  = 2'b01,
		SRC_MUTE = 2'b10,
		SRC_GEN  = 2'b11
	} sif_src_t;
	typedef enum logic [1:0] {
		LED_OFF = 2'b00,
		LED_RED = 2'b01,
		LED_ORG = 2'b10,
		LED_GRN = 2'b11
	} sif_led_t;
	typedef enum logic [1:0] {
		ST_LIVE   = 2'b00,
		ST_FREEZE = 2'b01,
		ST_GEN    = 2'b10,
		ST_RELOCK = 2'b11
	} sif_vst_t;
endpackage : sif_pkg
`default_nettype wire

// ===== testbench/sif_rx_model.sv
/*
 * Behavioural SDI receiver with reclocker, one instance per input.
 * Assumes the bench sets carrier and reclocker health; lock lags carrier.
 */
`timescale 1ns/1ps
`default_nettype none
module sif_rx_model #(
	parameter int LOCK_CYC = 4
) (
	input  wire logic clk_i,
	input  wire logic carrier_i,
	input  wire logic pll_ok_i,
	output logic      sig_o,
	output logic      lock_o
);
	int cnt_r = 0;

	// Lock only after the reclocker settles; a slow one keeps failover timing honest
	always_ff @(posedge clk_i) begin
		if (!(carrier_i && pll_ok_i))
			cnt_r <= 0;
		else if (cnt_r < LOCK_CYC)
			cnt_r <= cnt_r + 1;
	end

	// Lock drops at once with carrier or reclocker, never lingers
	assign sig_o  = carrier_i;
	assign lock_o = carrier_i && pll_ok_i && (cnt_r >= LOCK_CYC);
endmodule : sif_rx_model
`default_nettype wire

// ===== testbench/tb_top.sv
/*
 * Self-checking bench for the failover and status block.
 * Assumes the package constants and 1 ms hold/lock ticks of the design.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic [7:0]  addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000, rdata_o, v;
	logic        e_car = 1'b1, e_pll = 1'b1, o_car = 1'b1, o_pll = 1'b1;
	logic        elec_sig_i, elec_lock_i, opt_sig_i, opt_lock_i;
	logic        sync_sig_i = 1'b1, sync_lock_i = 1'b1, fuse_trip_i = 1'b0, prog_fail_i = 1'b0;
	logic        remote_override_switch_i = 1'b0, factory_default_switch_i = 1'b0;
	logic        input_medium_select_i = 1'b0, reboot_o, freeze_o, gen_sel_o, alarm_oe_o;
	logic        out1_processed_select_i = 1'b0, out2_processed_select_i = 1'b0;
	logic        out1_processed_o, out2_processed_o;
	logic [2:0]  audio_groups_i = 3'h4;
	logic [3:0]  gpi_n_i = 4'b1010;
	logic [1:0]  src_sel_o, prio_level_o, led_card_o, led_video_o, led_sync_o, led_audio_o;
	int          fail_count = 0, checked = 0, n;

	sif_top sif_top_inst (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.elec_sig_i, .elec_lock_i, .opt_sig_i, .opt_lock_i, .sync_sig_i, .sync_lock_i,
		.audio_groups_i, .fuse_trip_i, .prog_fail_i, .remote_override_switch_i,
		.factory_default_switch_i, .input_medium_select_i, .out1_processed_select_i,
		.out2_processed_select_i, .gpi_n_i, .src_sel_o, .freeze_o, .gen_sel_o,
		.prio_level_o, .out1_processed_o, .out2_processed_o, .led_card_o, .led_video_o,
		.led_sync_o, .led_audio_o, .alarm_oe_o, .reboot_o);
	// Prompt electrical receiver, slow optical one
	sif_rx_model #(.LOCK_CYC(4)) rx_elec_inst (.clk_i(clk_i), .carrier_i(e_car),
		.pll_ok_i(e_pll), .sig_o(elec_sig_i), .lock_o(elec_lock_i));
	sif_rx_model #(.LOCK_CYC(40)) rx_opt_inst (.clk_i(clk_i), .carrier_i(o_car),
		.pll_ok_i(o_pll), .sig_o(opt_sig_i), .lock_o(opt_lock_i));

	always #20 clk_i = ~clk_i;

	// Compare and report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Bus cycles: strobes one cycle, read data only in the following cycle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	task automatic idle(input int c);
		repeat (c) @(posedge clk_i);
	endtask : idle

	// Bounded wait for a level and source, then compare both
	task automatic wait_lvl(input logic [1:0] l, input logic [1:0] s, input int maxc);
		for (int i = 0; i < maxc && {prio_level_o, src_sel_o} !== {l, s}; i++)
			@(posedge clk_i);
		chk({12'h000, prio_level_o, src_sel_o}, {12'h000, l, s});
	endtask : wait_lvl

	// Straps set during reset; sampling lands a few edges after release
	task automatic do_reset(input logic o, input logic f, input logic m);
		@(posedge clk_i);
		rst_i <= 1'b1;
		remote_override_switch_i <= o;
		factory_default_switch_i <= f;
		input_medium_select_i    <= m;
		idle(4);
		rst_i <= 1'b0;
		idle(10);
	endtask : do_reset

	task automatic finish_test();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// Watchdog past one hold of 1 ms plus one lock of 2 ms and the short tests
	initial begin
		repeat (95000) @(posedge clk_i);
		fail_count++;
		finish_test();
	end

	initial begin
		do_reset(1'b0, 1'b0, 1'b0);
		rd(sif_pkg::A_CTRL, v); chk(v, {8'h00, sif_pkg::CTRL_RST});
		rd(sif_pkg::A_PRIO, v); chk(v, {10'h000, sif_pkg::PRIO_RST});
		rd(sif_pkg::A_HOLD, v); chk(v, sif_pkg::HOLD_RST);
		rd(sif_pkg::A_LOCK, v); chk(v, sif_pkg::LOCK_RST);
		rd(8'h20, v); chk(v, 16'h0000);
		rd(sif_pkg::A_STAT, v); chk({12'h000, v[15:12]}, 16'h0005);
		$display("test registers done");
		// Manual source and output switch for every code
		for (int i = 0; i < 4; i++) begin
			wr(sif_pkg::A_CTRL, {8'h00, i[1], i[0], i[1:0], 4'h0});
			idle(6);
			chk({12'h000, src_sel_o, out2_processed_o, out1_processed_o},
				{12'h000, i[1:0], i[1], i[0]});
		end
		$display("test manual done");
		wr(sif_pkg::A_CTRL, 16'h0000);
		// Absent, present unlocked, locked for video, sync and audio
		for (int k = 0; k < 3; k++) begin
			e_car <= (k > 0);
			e_pll <= (k == 2);
			sync_sig_i <= (k > 0);
			sync_lock_i <= (k == 2);
			audio_groups_i <= 3'(2 * k);
			idle(20);
			chk({10'h000, led_video_o, led_sync_o, led_audio_o},
				{10'h000, 2'(k + 1), 2'(k + 1), 2'(k + 1)});
		end
		chk({13'h0000, led_card_o, alarm_oe_o}, {13'h0000, sif_pkg::LED_GRN, 1'b1});
		fuse_trip_i <= 1'b1;
		idle(6);
		chk({13'h0000, led_card_o, alarm_oe_o}, {13'h0000, sif_pkg::LED_RED, 1'b0});
		fuse_trip_i <= 1'b0;
		prog_fail_i <= 1'b1;
		idle(6);
		chk({13'h0000, led_card_o, alarm_oe_o}, {13'h0000, sif_pkg::LED_RED, 1'b0});
		prog_fail_i <= 1'b0;
		$display("test indicators done");
		// Locate lights all four indicators together
		wr(sif_pkg::A_CMD, 16'h0002);
		idle(3);
		chk({8'h00, led_card_o, led_video_o, led_sync_o, led_audio_o}, 16'h00ff);
		// Download done: running light starts on the card indicator, alarm open
		wr(sif_pkg::A_CMD, 16'h0004);
		idle(3);
		chk({7'h00, led_card_o, led_video_o, led_sync_o, led_audio_o, alarm_oe_o},
			16'h0180);
		wr(sif_pkg::A_CMD, 16'h0008);
		n = 0;
		// Pulse stands from the strobe's sampling edge to the next one
		repeat (10) begin
			#1 n += int'(reboot_o === 1'b1);
			@(posedge clk_i);
		end
		chk(16'(n), 16'h0001);
		$display("test locate and install done");
		// Straps read once at power-up only
		out1_processed_select_i <= 1'b1;
		do_reset(1'b1, 1'b0, 1'b1);
		remote_override_switch_i <= 1'b0;
		idle(10);
		chk({13'h0000, src_sel_o, out1_processed_o}, {13'h0000, sif_pkg::SRC_OPT, 1'b1});
		do_reset(1'b1, 1'b1, 1'b0);
		chk({14'h0000, led_card_o}, {14'h0000, sif_pkg::LED_ORG});
		rd(sif_pkg::A_HOLD, v); chk(v, sif_pkg::HOLD_RST);
		$display("test straps done");
		// Manual hold and relock timing, then automatic failover, loss of lock, latched
		do_reset(1'b0, 1'b0, 1'b0);
		wr(sif_pkg::A_HOLD, 16'h0001);
		wr(sif_pkg::A_LOCK, 16'h0002);
		// Manual loss: freeze, generator after hold, live only after lock time
		wr(sif_pkg::A_CTRL, 16'h0000);
		e_car <= 1'b0;
		for (n = 0; n < 20 && freeze_o !== 1'b1; n++)
			@(posedge clk_i);
		chk({14'h0000, freeze_o, gen_sel_o}, 16'h0002);
		for (n = 0; n < 30000 && gen_sel_o !== 1'b1; n++)
			@(posedge clk_i);
		chk({14'h0000, freeze_o, gen_sel_o}, 16'h0001);
		e_car <= 1'b1;
		for (n = 0; n < 60000 && gen_sel_o !== 1'b0; n++)
			@(posedge clk_i);
		chk({15'h0000, n >= sif_pkg::MS_CYC}, 16'h0001);
		chk({15'h0000, gen_sel_o}, 16'h0000);
		$display("test hold and relock done");
		wr(sif_pkg::A_CTRL, 16'h0001);
		wait_lvl(2'd0, sif_pkg::SRC_OPT, 200);
		o_pll <= 1'b0;
		idle(100);
		// Healthy backup takes over at once; the carrier stays, so the picture never freezes
		chk({15'h0000, freeze_o}, 16'h0000);
		wait_lvl(2'd1, sif_pkg::SRC_ELEC, 30000);
		o_pll <= 1'b1;
		idle(300);
		chk({14'h0000, prio_level_o}, 16'h0001);
		e_car <= 1'b0;
		wait_lvl(2'd2, sif_pkg::SRC_GEN, 30000);
		e_car <= 1'b1;
		wr(sif_pkg::A_CTRL, 16'h0003);
		wait_lvl(2'd0, sif_pkg::SRC_OPT, 200);
		$display("test latched failover done");
		// Loss of signal, non-latched: returns as soon as main signal is back, lock not needed
		wr(sif_pkg::A_CTRL, 16'h0007);
		o_car <= 1'b0;
		wait_lvl(2'd1, sif_pkg::SRC_ELEC, 30000);
		o_car <= 1'b1;
		wait_lvl(2'd0, sif_pkg::SRC_OPT, 60000);
		$display("test non-latched failover done");
		// Backup 2 marked unused: cascade stops at backup 1
		wr(sif_pkg::A_PRIO, 16'h0071);
		wr(sif_pkg::A_CTRL, 16'h0001);
		o_pll <= 1'b0;
		wait_lvl(2'd1, sif_pkg::SRC_ELEC, 200);
		e_car <= 1'b0;
		idle(50);
		chk({12'h000, prio_level_o, src_sel_o}, {12'h000, 2'd1, sif_pkg::SRC_ELEC});
		e_car <= 1'b1;
		o_pll <= 1'b1;
		$display("test unused backup done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
